// ---- core/slpc_pkg.sv ----
// constants and types of the sleep-mode power controller
// What this block does
// R01 - sleep needs arm bit plus sleep instruction
// R02 - mode codes: 00 idle, 01 noise, 10 powerdown
// R03 - interrupt wake: halt four cycles after start-up
// R04 - wake never clears register file or SRAM
// R05 - reset during sleep restarts at reset vector
// R06 - idle stops cpu and flash clocks only
// R07 - idle wakes on any enabled interrupt
// R08 - comparator power-off bit lowers idle consumption
// R09 - idle or noise mode starts enabled conversion
// R10 - noise mode also stops io clock
// R11 - noise mode wakes on listed sources only
// R12 - powerdown stops oscillator and all clocks
// R13 - powerdown wake excludes memory-ready and converter
// R14 - external irqs wake deep modes when level
// R15 - waking level must be held long enough
// R16 - powerdown wake waits selected start-up time
// R17 - detector off in sleep, on at wake; code turns it off in powerdown only
// R18 - detector off means reset-length wake delay
// R19 - bit 6 turns detector off, resets zero
// R20 - detector-off bit written via unlock sequence
// R21 - second write within four cycles of unlock
// R22 - bit active after three, clears three later
// R23 - unarmed or unused mode just continues
package slpc_pkg;
    localparam logic [7:0] ADDR_SLEEP_CTRL = 8'h00;
    localparam logic [7:0] ADDR_MCU_CTRL = 8'h04;
    localparam logic [7:0] ADDR_CONFIG = 8'h08;
    localparam logic [7:0] ADDR_TIMING = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam int SLP_ARM_BIT = 0;
    localparam int SLP_MODE_LSB = 1;
    localparam int BROWNOUT_SLEEP_OFF_BIT = 6;
    localparam int BROWNOUT_SLEEP_UNLOCK_BIT = 5;
    localparam int CMP_OFF_BIT = 0;
    localparam int CONV_EN_BIT = 1;
    localparam logic [15:0] STARTUP_CYC_RST = 16'h0006;
    localparam logic [15:0] RESET_CYC_RST = 16'h0014;
    localparam logic [2:0] UNLOCK_CYC = 3'h4;
    localparam logic [2:0] BROWNOUT_SLEEP_OFF_DELAY_CYC = 3'h3;
    localparam logic [2:0] BROWNOUT_SLEEP_OFF_HOLD_CYC = 3'h3;
    localparam logic [2:0] WAKE_HALT_CYC = 3'h4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        SLPC_IDLE = 2'b00,
        SLPC_NOISE = 2'b01,
        SLPC_PDOWN = 2'b10,
        SLPC_UNUSED = 2'b11
    } slpc_mode_t;
    typedef enum logic [2:0] {
        SLPC_RUN = 3'b000,
        SLPC_SLEEP = 3'b001,
        SLPC_START = 3'b010,
        SLPC_HALT = 3'b011
    } slpc_state_t;
endpackage

// ---- core/slpc_sleep_ctrl.sv ----
// sleep-mode power controller with AXI4-Lite registers
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module slpc_sleep_ctrl import slpc_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sleep_instr,
    input wire logic irq_other,
    input wire logic [1:0] ext_irq_req,
    input wire logic [1:0] ext_irq_level,
    input wire logic pin_change_req,
    input wire logic twi_match_req,
    input wire logic wdog_irq_req,
    input wire logic conv_done_req,
    input wire logic mem_ready_req,
    input wire logic sys_reset_req,
    output logic cpu_clk_en,
    output logic flash_clk_en,
    output logic io_clk_en,
    output logic conv_clk_en,
    output logic osc_en,
    output logic comparator_en,
    output logic bod_en,
    output logic conv_start,
    output logic core_halt,
    output logic core_continue,
    output logic irq_go,
    output logic reset_vector
);
    logic sleep_arm;
    slpc_mode_t sleep_mode_select;
    logic comparator_power_off;
    logic conv_enable;
    logic [15:0] startup_cyc;
    logic [15:0] reset_cyc;
    logic [2:0] unlock_cnt;
    logic [2:0] brownout_sleep_off_cnt;
    logic brownout_sleep_off_active;
    slpc_state_t state;
    slpc_mode_t cur_mode;
    logic bod_was_off;
    logic wake_by_reset;
    logic [15:0] delay_cnt;
    logic [2:0] halt_cnt;
    logic [7:0] aw_addr;
    logic aw_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_full;
    logic do_write;
    logic wake_now;
    logic enter_ok;

    // wake sources allowed in each mode
    function automatic logic wake_allowed(
        input slpc_mode_t m,
        input logic other,
        input logic [1:0] ei,
        input logic [1:0] lvl,
        input logic pc,
        input logic two_wire_serial,
        input logic wd,
        input logic conv,
        input logic mem
    );
        logic deep;
        deep = pc | two_wire_serial | wd | (|(ei & lvl)); // see R14
        case (m)
            SLPC_IDLE: wake_allowed = deep | other | (|ei) | conv | mem; // see R07
            SLPC_NOISE: wake_allowed = deep | conv | mem; // see R11
            SLPC_PDOWN: wake_allowed = deep; // see R13
            default: wake_allowed = 1'b0;
        endcase
    endfunction

    assign do_write = aw_full & w_full & ~s_axi_bvalid;
    assign wake_now = wake_allowed(cur_mode, irq_other, ext_irq_req,
        ext_irq_level, pin_change_req, twi_match_req, wdog_irq_req,
        conv_done_req, mem_ready_req);
    assign enter_ok = sleep_arm & (sleep_mode_select != SLPC_UNUSED); // see R01 R23

    // write address and data are taken in either order and held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
                aw_full <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                w_full <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_addr)
                    ADDR_SLEEP_CTRL, ADDR_MCU_CTRL, ADDR_CONFIG, ADDR_TIMING, ADDR_STATUS:
                        s_axi_bresp <= RESP_OKAY;
                    default: s_axi_bresp <= RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // plain control registers; status writes are ignored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sleep_arm <= 1'b0;
            sleep_mode_select <= SLPC_IDLE;
            comparator_power_off <= 1'b0;
            conv_enable <= 1'b0;
            startup_cyc <= STARTUP_CYC_RST;
            reset_cyc <= RESET_CYC_RST;
        end else if (clk_en && do_write) begin
            if (aw_addr == ADDR_SLEEP_CTRL && w_strb[0]) begin
                sleep_arm <= w_data[SLP_ARM_BIT];
                sleep_mode_select <= slpc_mode_t'(w_data[SLP_MODE_LSB +: 2]);
            end
            if (aw_addr == ADDR_CONFIG && w_strb[0]) begin
                comparator_power_off <= w_data[CMP_OFF_BIT]; // see R08
                conv_enable <= w_data[CONV_EN_BIT];
            end
            if (aw_addr == ADDR_TIMING) begin
                if (w_strb[0]) startup_cyc[7:0] <= w_data[7:0];
                if (w_strb[1]) startup_cyc[15:8] <= w_data[15:8];
                if (w_strb[2]) reset_cyc[7:0] <= w_data[23:16];
                if (w_strb[3]) reset_cyc[15:8] <= w_data[31:24];
            end
        end
    end

    // timed unlock: first write opens a window, late second write is lost
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            unlock_cnt <= 3'h0;
            brownout_sleep_off_cnt <= 3'h0;
        end else if (clk_en) begin
            if (unlock_cnt != 3'h0) unlock_cnt <= unlock_cnt - 3'h1; // see R21
            if (brownout_sleep_off_cnt != 3'h0) brownout_sleep_off_cnt <= brownout_sleep_off_cnt - 3'h1; // see R22
            if (do_write && aw_addr == ADDR_MCU_CTRL && w_strb[0]) begin
                if (w_data[BROWNOUT_SLEEP_OFF_BIT] && w_data[BROWNOUT_SLEEP_UNLOCK_BIT]) begin
                    // a rewrite inside the window does not extend it
                    if (unlock_cnt == 3'h0) unlock_cnt <= UNLOCK_CYC; // see R20
                end else if (w_data[BROWNOUT_SLEEP_OFF_BIT] && unlock_cnt != 3'h0) begin
                    unlock_cnt <= 3'h0;
                    brownout_sleep_off_cnt <= BROWNOUT_SLEEP_OFF_DELAY_CYC + BROWNOUT_SLEEP_OFF_HOLD_CYC; // see R21
                end
            end
        end
    end

    // active only in the last three counts, then clears itself
    assign brownout_sleep_off_active = (brownout_sleep_off_cnt != 3'h0) && (brownout_sleep_off_cnt <= BROWNOUT_SLEEP_OFF_HOLD_CYC); // see R22

    // sleep sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= SLPC_RUN;
            cur_mode <= SLPC_IDLE;
            bod_was_off <= 1'b0;
            wake_by_reset <= 1'b0;
            delay_cnt <= 16'h0000;
            halt_cnt <= 3'h0;
        end else if (clk_en) begin
            case (state)
                SLPC_RUN: begin
                    if (sleep_instr && enter_ok) begin
                        state <= SLPC_SLEEP;
                        cur_mode <= sleep_mode_select; // see R02
                        bod_was_off <= brownout_sleep_off_active && sleep_mode_select == SLPC_PDOWN; // see R17
                        wake_by_reset <= 1'b0;
                    end
                end
                SLPC_SLEEP: begin
                    if (sys_reset_req || wake_now) begin
                        state <= SLPC_START;
                        wake_by_reset <= sys_reset_req; // see R05
                        // only a stopped oscillator needs a restart delay
                        if (bod_was_off)
                            delay_cnt <= reset_cyc; // see R18
                        else if (cur_mode == SLPC_PDOWN)
                            delay_cnt <= startup_cyc; // see R16
                        else
                            delay_cnt <= 16'h0000;
                    end
                end
                SLPC_START: begin
                    if (delay_cnt != 16'h0000) begin
                        delay_cnt <= delay_cnt - 16'h0001;
                    end else if (wake_by_reset) begin
                        state <= SLPC_RUN;
                    end else begin
                        state <= SLPC_HALT;
                        halt_cnt <= WAKE_HALT_CYC - 3'h1; // see R03
                    end
                end
                SLPC_HALT: begin
                    if (halt_cnt == 3'h0) state <= SLPC_RUN;
                    else halt_cnt <= halt_cnt - 3'h1; // see R03
                end
                default: state <= SLPC_RUN;
            endcase
        end
    end

    // clock gating per mode; the core keeps its state, nothing is cleared
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_clk_en <= 1'b1;
            flash_clk_en <= 1'b1;
            io_clk_en <= 1'b1;
            conv_clk_en <= 1'b1;
            osc_en <= 1'b1;
            comparator_en <= 1'b1;
            bod_en <= 1'b1;
        end else if (clk_en) begin
            comparator_en <= ~comparator_power_off; // see R08
            if (state == SLPC_RUN && sleep_instr && enter_ok) begin
                cpu_clk_en <= 1'b0; // see R06
                flash_clk_en <= 1'b0; // see R06
                io_clk_en <= sleep_mode_select == SLPC_IDLE; // see R10
                conv_clk_en <= sleep_mode_select != SLPC_PDOWN; // see R12
                osc_en <= sleep_mode_select != SLPC_PDOWN; // see R12
                if (brownout_sleep_off_active && sleep_mode_select == SLPC_PDOWN)
                    bod_en <= 1'b0; // see R17
            end else if (state == SLPC_SLEEP && (sys_reset_req || wake_now)) begin
                osc_en <= 1'b1;
                bod_en <= 1'b1; // see R17
            end else if (state == SLPC_START && delay_cnt == 16'h0000) begin
                cpu_clk_en <= 1'b1; // see R04
                flash_clk_en <= 1'b1;
                io_clk_en <= 1'b1;
                conv_clk_en <= 1'b1;
            end
        end
    end

    // one-cycle strobes to the core and converter, and the core_halt level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_start <= 1'b0;
            core_continue <= 1'b0;
            irq_go <= 1'b0;
            reset_vector <= 1'b0;
            core_halt <= 1'b0;
        end else if (clk_en) begin
            conv_start <= state == SLPC_RUN && sleep_instr && enter_ok && conv_enable
                && sleep_mode_select != SLPC_PDOWN; // see R09
            core_continue <= state == SLPC_RUN && sleep_instr && !enter_ok; // see R23
            irq_go <= state == SLPC_HALT && halt_cnt == 3'h0; // see R03
            reset_vector <= state == SLPC_START && delay_cnt == 16'h0000
                && wake_by_reset; // see R05
            core_halt <= (state == SLPC_RUN && sleep_instr && enter_ok)
                || (state != SLPC_RUN && !(state == SLPC_HALT && halt_cnt == 3'h0)
                && !(state == SLPC_START && delay_cnt == 16'h0000 && wake_by_reset));
        end
    end

    // read channel, one word per request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                s_axi_rdata <= 32'h0000_0000;
                case (s_axi_araddr)
                    ADDR_SLEEP_CTRL: begin
                        s_axi_rdata[SLP_ARM_BIT] <= sleep_arm;
                        s_axi_rdata[SLP_MODE_LSB +: 2] <= sleep_mode_select;
                    end
                    ADDR_MCU_CTRL: begin
                        s_axi_rdata[BROWNOUT_SLEEP_OFF_BIT] <= brownout_sleep_off_cnt != 3'h0; // see R19
                        s_axi_rdata[BROWNOUT_SLEEP_UNLOCK_BIT] <= unlock_cnt != 3'h0;
                    end
                    ADDR_CONFIG: begin
                        s_axi_rdata[CMP_OFF_BIT] <= comparator_power_off;
                        s_axi_rdata[CONV_EN_BIT] <= conv_enable;
                    end
                    ADDR_TIMING: s_axi_rdata <= {reset_cyc, startup_cyc};
                    ADDR_STATUS: s_axi_rdata[8:0] <= {bod_was_off, wake_by_reset,
                        brownout_sleep_off_active, cur_mode, 1'b0, state};
                    default: s_axi_rresp <= RESP_SLVERR;
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule

// ---- verif/slpc_checker.sv ----
// assertions on the sleep controller's core-side outputs
`timescale 1ns/10ps
module slpc_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sleep_instr,
    input wire logic cpu_clk_en,
    input wire logic flash_clk_en,
    input wire logic io_clk_en,
    input wire logic conv_clk_en,
    input wire logic osc_en,
    input wire logic bod_en,
    input wire logic conv_start,
    input wire logic core_halt,
    input wire logic core_continue,
    input wire logic irq_go,
    input wire logic reset_vector
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // gating only ever follows a sleep instruction
    entry_cause_a: assert property ($fell(cpu_clk_en) |-> $past(sleep_instr))
        else $error("clocks gated without sleep instruction");
    cpu_flash_pair_a: assert property (cpu_clk_en == flash_clk_en)
        else $error("cpu and flash clock enables differ");
    io_stop_a: assert property (!io_clk_en |-> !cpu_clk_en)
        else $error("io clock stopped while cpu runs");
    osc_stop_a: assert property (!osc_en |-> !conv_clk_en && !io_clk_en)
        else $error("clock running with oscillator off");
    // interrupt wake: four halted cycles once clocks return, then the handler
    halt_four_a: assert property ($rose(cpu_clk_en) && !reset_vector |-> core_halt[*4] ##1 (irq_go && !core_halt))
        else $error("halt after wake not four cycles");
    reset_wake_a: assert property (reset_vector |-> cpu_clk_en && !core_halt && !irq_go)
        else $error("reset vector without running core");
    bod_off_a: assert property (!bod_en |-> !osc_en)
        else $error("detector off outside power-down");
    bod_back_a: assert property ($rose(osc_en) |-> bod_en)
        else $error("detector not back at wake");
    conv_kick_a: assert property (conv_start |-> conv_clk_en && osc_en && !cpu_clk_en)
        else $error("conversion start outside idle or noise sleep");
    cont_run_a: assert property (core_continue |-> cpu_clk_en && !core_halt)
        else $error("continue while core gated");
endmodule

bind slpc_sleep_ctrl slpc_checker u_chk (.aclk, .aresetn, .sleep_instr, .cpu_clk_en, .flash_clk_en, .io_clk_en,
    .conv_clk_en, .osc_en, .bod_en, .conv_start, .core_halt, .core_continue, .irq_go, .reset_vector);

// ---- verif/slpc_core_model.sv ----
// cpu core stand-in: issues sleep instructions and holds wake lines
`timescale 1ns/10ps
module slpc_core_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic exec,
    input wire logic [7:0] req,
    input wire logic irq_go,
    input wire logic reset_vector,
    output logic sleep_instr = 1'b0,
    output logic [7:0] src = 8'h00
);
    // one sleep instruction per requested cycle
    always @(posedge aclk) begin
        sleep_instr <= aresetn && exec;
    end
    // levels stay until the handler or reset vector starts, else the wake is lost
    always @(posedge aclk) begin
        if (!aresetn || irq_go || reset_vector) begin
            src <= 8'h00;
        end else begin
            src <= src | req;
        end
    end
endmodule

// ---- verif/sleep_mode_power_controller_bench.sv ----
// self-checking bench for the sleep-mode power controller
`timescale 1ns/10ps
module sleep_mode_power_controller_bench import slpc_pkg::*;;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0, exec = 1'b0, rst_req = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, req = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [1:0] lvl = 2'h0;
    logic awready, wready, bvalid, arready, rvalid, sleep_instr, cpu, flash, io, conv, osc, cmp, brownout_detector;
    logic cstart, halt, cont, irq_go, rvec;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] src;
    int err_count = 0, tests_run = 0, base, n;
    int conts = 0, starts = 0;
    initial begin
        forever #4 aclk = ~aclk;
    end
    slpc_sleep_ctrl uut (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sleep_instr(sleep_instr), .irq_other(src[0]), .ext_irq_req(src[2:1]), .ext_irq_level(lvl),
        .pin_change_req(src[3]), .twi_match_req(src[4]), .wdog_irq_req(src[5]), .conv_done_req(src[6]),
        .mem_ready_req(src[7]), .sys_reset_req(rst_req), .cpu_clk_en(cpu), .flash_clk_en(flash),
        .io_clk_en(io), .conv_clk_en(conv), .osc_en(osc), .comparator_en(cmp), .bod_en(brownout_detector),
        .conv_start(cstart), .core_halt(halt), .core_continue(cont), .irq_go(irq_go), .reset_vector(rvec));
    // count the one-cycle strobes so scenarios can judge them afterwards
    always @(posedge aclk) begin
        if (cont) conts++;
        if (cstart) starts++;
    end
    slpc_core_model core (.aclk(aclk), .aresetn(aresetn), .exec(exec), .req(req), .irq_go(irq_go),
        .reset_vector(rvec), .sleep_instr(sleep_instr), .src(src));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awv <= 1'b0;
            if (wready) wv <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arv <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
    endtask
    task automatic slp(input logic [7:0] c);
        wr(ADDR_SLEEP_CTRL, {24'h0, c}, RESP_OKAY);
        exec <= 1'b1;
        @(posedge aclk);
        exec <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask
    // edges from a wake request until the cpu clock returns; 40 means it stayed asleep
    task automatic wake(input logic [7:0] m, input logic r, output int k);
        req <= m;
        rst_req <= r;
        @(posedge aclk);
        req <= 8'h00;
        k = 0;
        while (!cpu && k < 40) begin
            @(posedge aclk);
            k++;
        end
    endtask
    task automatic settle();
        for (int i = 0; i < 20 && !(irq_go || rvec); i++) begin
            @(posedge aclk);
        end
        chkb(irq_go || rvec, 1'b1);
        rst_req <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask
    task automatic t_regs();
        rd(ADDR_SLEEP_CTRL, 32'h0, RESP_OKAY);
        rd(ADDR_MCU_CTRL, 32'h0, RESP_OKAY);
        rd(8'h14, 32'h0, RESP_SLVERR);
        wr(8'h14, 32'h1, RESP_SLVERR);
        wr(ADDR_CONFIG, 32'h3, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chkb(cmp, 1'b0);
        slp(8'h04);
        chkb(cpu, 1'b1);
        slp(8'h07);
        chkb(cpu & osc, 1'b1);
        chk(conts, 2);
    endtask
    task automatic t_idle();
        slp(8'h01);
        chkb(cpu | flash, 1'b0);
        chkb(io & conv & osc, 1'b1);
        wake(8'h02, 1'b0, base);
        settle();
    endtask
    task automatic t_noise();
        slp(8'h03);
        chkb(io, 1'b0);
        chkb(conv, 1'b1);
        chk(starts, 2);
        wake(8'h02, 1'b0, n);
        chk(n, 40);
        wake(8'h80, 1'b0, n);
        chk(n, base);
        settle();
    endtask
    task automatic t_pdown();
        slp(8'h05);
        chkb(osc | conv | io, 1'b0);
        chk(starts, 2);
        wake(8'hC0, 1'b0, n);
        chk(n, 40);
        lvl <= 2'h1;
        wake(8'h02, 1'b0, n);
        chk(n, base + int'(STARTUP_CYC_RST));
        settle();
        slp(8'h05);
        wake(8'h00, 1'b1, n);
        // the reset line skips the core model's register stage, so it is seen one edge sooner
        chk(n, base - 1 + int'(STARTUP_CYC_RST));
        chkb(rvec, 1'b1);
        settle();
    endtask
    // the sleep has to land while the detector-off bit is active
    task automatic t_brownout_sleep_off();
        wr(ADDR_SLEEP_CTRL, 32'h5, RESP_OKAY);
        wr(ADDR_MCU_CTRL, 32'h60, RESP_OKAY);
        wr(ADDR_MCU_CTRL, 32'h40, RESP_OKAY);
        @(posedge aclk);
        exec <= 1'b1;
        @(posedge aclk);
        exec <= 1'b0;
        repeat (3) @(posedge aclk);
        chkb(brownout_detector, 1'b0);
        wake(8'h08, 1'b0, n);
        chk(n, base + int'(RESET_CYC_RST));
        settle();
        chkb(brownout_detector, 1'b1);
        wr(ADDR_MCU_CTRL, 32'h60, RESP_OKAY);
        repeat (6) @(posedge aclk);
        wr(ADDR_MCU_CTRL, 32'h40, RESP_OKAY);
        rd(ADDR_MCU_CTRL, 32'h0, RESP_OKAY);
    endtask
    task automatic print_verdict();
        if (err_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_idle();
        t_noise();
        t_pdown();
        t_brownout_sleep_off();
        print_verdict();
    end
    // a hang ends the run as a failure
    initial begin
        #50us;
        err_count++;
        print_verdict();
    end
endmodule
